// ==== hdl/channel_cal_config_defs.vh ====
// register offsets, field positions, reset values for channel config/calibration bank
`ifndef CHANNEL_CAL_CONFIG_DEFS_VH
`define CHANNEL_CAL_CONFIG_DEFS_VH

// word addresses
`define ADDR_CHAN_ZERO_GAIN_CAL_LOW  6'h0d
`define ADDR_CHANNEL_ONE_CONFIG      6'h0e
`define ADDR_CHAN_ONE_OFFSET_HIGH    6'h0f
`define ADDR_CHAN_ONE_OFFSET_LOW     6'h10
`define ADDR_CHAN_ONE_GAIN_HIGH      6'h11
`define ADDR_CHAN_ONE_GAIN_LOW       6'h12
`define ADDR_CHANNEL_TWO_CONFIG      6'h13
`define ADDR_DC_BLOCK_SETTING        6'h14

// reset values
`define RESET_CONFIG      16'h0000
`define RESET_PHASE       10'h000
`define RESET_OFFSET_HIGH 16'h0000
`define RESET_GAIN_HIGH   16'h8000
`define RESET_LOW_BYTE    8'h00
`define RESET_DC_BLOCK    4'h0

// configuration word fields
`define CFG_PHASE_HI   15
`define CFG_PHASE_LO   6
`define CFG_BYPASS_BIT 2
`define CFG_SELECT_HI  1
`define CFG_SELECT_LO  0

// input selection codes
`define SELECT_PINS     2'h0
`define SELECT_SHORTED  2'h1
`define SELECT_TEST_POS 2'h2
`define SELECT_TEST_NEG 2'h3

// dc block code for filter off
`define DC_BLOCK_OFF 4'h0

`endif

// ==== hdl/channel_config_word.v ====
// one channel configuration word: phase delay, dc block bypass, input select
`default_nettype none
`include "channel_cal_config_defs.vh"

module channel_config_word (
    // clock and reset
    input  wire        clock,
    input  wire        rst_n,
    // write port
    input  wire        write_enable,
    input  wire [15:0] write_data,
    // fields
    output reg  [9:0]  phase_delay,
    output reg         dc_block_bypass,
    output reg  [1:0]  input_select,
    output wire [15:0] read_word
);

    always @(posedge clock) begin
        if (!rst_n) begin
            phase_delay     <= `RESET_PHASE;
            dc_block_bypass <= 1'b0;
            input_select    <= `SELECT_PINS;
        end else if (write_enable) begin
            phase_delay     <= write_data[`CFG_PHASE_HI:`CFG_PHASE_LO];
            dc_block_bypass <= write_data[`CFG_BYPASS_BIT];
            input_select    <= write_data[`CFG_SELECT_HI:`CFG_SELECT_LO];
        end
    end

    // reserved bits 5:3 held at zero
    assign read_word = {phase_delay, 3'h0, dc_block_bypass, input_select};

endmodule // channel_config_word

`default_nettype wire

// ==== hdl/channel_cal_config_regs.v ====
// register bank for channel one and two configuration words and calibration words
//
// The address-and-strobe port was decided locally.
`default_nettype none
`include "channel_cal_config_defs.vh"

module channel_cal_config_regs (
    // clock and reset
    input  wire        clock,
    input  wire        rst_n,
    // register port
    input  wire [5:0]  address,
    input  wire [15:0] write_data,
    input  wire        write_strobe,
    input  wire        read_strobe,
    output reg  [15:0] read_data,
    // channel one settings
    output wire [9:0]  chan_one_phase_delay,
    output wire        chan_one_dc_block_bypass,
    output wire [1:0]  chan_one_input_select,
    output wire        chan_one_dc_block_active,
    output wire [23:0] chan_one_offset,
    output wire [23:0] chan_one_gain,
    // channel two settings
    output wire [9:0]  chan_two_phase_delay,
    output wire        chan_two_dc_block_bypass,
    output wire [1:0]  chan_two_input_select,
    output wire        chan_two_dc_block_active,
    // shared settings
    output wire [3:0]  global_dc_block_coefficient,
    output wire [7:0]  chan_zero_gain_low_bits
);

    // ==========================================================
    // storage
    reg  [15:0] chan_one_offset_high_bits;
    reg  [7:0]  chan_one_offset_low_bits;
    reg  [15:0] chan_one_gain_high_bits;
    reg  [7:0]  chan_one_gain_low_bits;
    reg  [7:0]  chan_zero_gain_low;
    reg  [3:0]  dc_block_setting;
    wire [15:0] chan_one_word;
    wire [15:0] chan_two_word;
    reg  [15:0] next_read_data;

    wire write_one = write_strobe && (address == `ADDR_CHANNEL_ONE_CONFIG);
    wire write_two = write_strobe && (address == `ADDR_CHANNEL_TWO_CONFIG);

    // ==========================================================
    // configuration words, one per channel
    wire [1:0]  cfg_write;
    wire [19:0] cfg_phase;
    wire [1:0]  cfg_bypass;
    wire [3:0]  cfg_select;
    wire [31:0] cfg_word;

    assign cfg_write = {write_two, write_one};

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : cfg_channel
            channel_config_word channel_config_word_inst (
                .clock           (clock),
                .rst_n           (rst_n),
                .write_enable    (cfg_write[g]),
                .write_data      (write_data),
                .phase_delay     (cfg_phase[g*10 +: 10]),
                .dc_block_bypass (cfg_bypass[g]),
                .input_select    (cfg_select[g*2 +: 2]),
                .read_word       (cfg_word[g*16 +: 16])
            );
        end
    endgenerate

    assign chan_one_phase_delay     = cfg_phase[9:0];
    assign chan_one_dc_block_bypass = cfg_bypass[0];
    assign chan_one_input_select    = cfg_select[1:0];
    assign chan_one_word            = cfg_word[15:0];
    assign chan_two_phase_delay     = cfg_phase[19:10];
    assign chan_two_dc_block_bypass = cfg_bypass[1];
    assign chan_two_input_select    = cfg_select[3:2];
    assign chan_two_word            = cfg_word[31:16];

    // ==========================================================
    // calibration words and dc block setting
    always @(posedge clock) begin
        if (!rst_n) begin
            chan_one_offset_high_bits <= `RESET_OFFSET_HIGH;
            chan_one_offset_low_bits  <= `RESET_LOW_BYTE;
            chan_one_gain_high_bits   <= `RESET_GAIN_HIGH;
            chan_one_gain_low_bits    <= `RESET_LOW_BYTE;
            chan_zero_gain_low        <= `RESET_LOW_BYTE;
            dc_block_setting          <= `RESET_DC_BLOCK;
        end else if (write_strobe) begin
            case (address)
                `ADDR_CHAN_ONE_OFFSET_HIGH: begin
                    chan_one_offset_high_bits <= write_data;
                end
                `ADDR_CHAN_ONE_OFFSET_LOW: begin
                    chan_one_offset_low_bits <= write_data[15:8];
                end
                `ADDR_CHAN_ONE_GAIN_HIGH: begin
                    chan_one_gain_high_bits <= write_data;
                end
                `ADDR_CHAN_ONE_GAIN_LOW: begin
                    chan_one_gain_low_bits <= write_data[15:8];
                end
                `ADDR_CHAN_ZERO_GAIN_CAL_LOW: begin
                    chan_zero_gain_low <= write_data[15:8];
                end
                `ADDR_DC_BLOCK_SETTING: begin
                    dc_block_setting <= write_data[3:0];
                end
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // settings to the datapath
    assign chan_one_offset             = {chan_one_offset_high_bits, chan_one_offset_low_bits};
    assign chan_one_gain               = {chan_one_gain_high_bits, chan_one_gain_low_bits};
    assign global_dc_block_coefficient = dc_block_setting;
    assign chan_zero_gain_low_bits     = chan_zero_gain_low;

    // filter runs only with a nonzero shared code and no per-channel bypass
    assign chan_one_dc_block_active = (dc_block_setting != `DC_BLOCK_OFF) && !chan_one_dc_block_bypass;
    assign chan_two_dc_block_active = (dc_block_setting != `DC_BLOCK_OFF) && !chan_two_dc_block_bypass;

    // ==========================================================
    // read path, data one cycle after the strobe
    always @* begin
        case (address)
            `ADDR_CHAN_ZERO_GAIN_CAL_LOW: begin
                next_read_data = {chan_zero_gain_low, 8'h00};
            end
            `ADDR_CHANNEL_ONE_CONFIG: begin
                next_read_data = chan_one_word;
            end
            `ADDR_CHAN_ONE_OFFSET_HIGH: begin
                next_read_data = chan_one_offset_high_bits;
            end
            `ADDR_CHAN_ONE_OFFSET_LOW: begin
                next_read_data = {chan_one_offset_low_bits, 8'h00};
            end
            `ADDR_CHAN_ONE_GAIN_HIGH: begin
                next_read_data = chan_one_gain_high_bits;
            end
            `ADDR_CHAN_ONE_GAIN_LOW: begin
                next_read_data = {chan_one_gain_low_bits, 8'h00};
            end
            `ADDR_CHANNEL_TWO_CONFIG: begin
                next_read_data = chan_two_word;
            end
            `ADDR_DC_BLOCK_SETTING: begin
                next_read_data = {12'h000, dc_block_setting};
            end
            default: begin
                next_read_data = 16'h0000;
            end
        endcase
    end

    always @(posedge clock) begin
        if (!rst_n) begin
            read_data <= 16'h0000;
        end else if (read_strobe) begin
            read_data <= next_read_data;
        end else begin
            read_data <= 16'h0000;
        end
    end

endmodule // channel_cal_config_regs

`default_nettype wire

// ==== verification/channel_cal_config_regs_props.sv ====
// assertions for the channel config and calibration bank
`default_nettype none
`include "channel_cal_config_defs.vh"
module channel_cal_config_regs_props (
    // clock, reset, register port
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic [5:0]  address,
    input wire logic [15:0] write_data,
    input wire logic        write_strobe,
    input wire logic        read_strobe,
    input wire logic [15:0] read_data,
    // settings
    input wire logic [9:0]  chan_one_phase_delay,
    input wire logic        chan_one_dc_block_bypass,
    input wire logic [1:0]  chan_one_input_select,
    input wire logic        chan_one_dc_block_active,
    input wire logic [23:0] chan_one_offset,
    input wire logic [23:0] chan_one_gain,
    input wire logic [9:0]  chan_two_phase_delay,
    input wire logic        chan_two_dc_block_bypass,
    input wire logic [1:0]  chan_two_input_select,
    input wire logic [3:0]  global_dc_block_coefficient
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_cfg_wr;
        write_strobe && address == `ADDR_CHANNEL_ONE_CONFIG;
    endsequence
    sequence s_low_rd;
        read_strobe && (address == 6'h0d || address == 6'h10 || address == 6'h12);
    endsequence
    a_phase_write: assert property (s_cfg_wr |=> chan_one_phase_delay == $past(write_data[15:6]))
        else $error("phase delay not taken");
    a_bypass_select: assert property (s_cfg_wr |=> {chan_one_dc_block_bypass, chan_one_input_select} == $past(write_data[2:0]))
        else $error("bypass or select not taken");
    a_offset_high: assert property (write_strobe && address == 6'h0f |=> chan_one_offset[23:8] == $past(write_data))
        else $error("offset high not taken");
    a_low_reserved: assert property (s_low_rd |=> read_data[7:0] == 8'h00)
        else $error("low byte not zero");
    a_gain_readback: assert property (read_strobe && address == 6'h11 |=> read_data == $past(chan_one_gain[23:8]))
        else $error("gain high readback wrong");
    a_chan_two: assert property (write_strobe && address == 6'h13 |=> {chan_two_phase_delay, chan_two_dc_block_bypass,
        chan_two_input_select} == $past({write_data[15:6], write_data[2:0]}))
        else $error("channel two config not taken");
    a_cfg_reserved: assert property (read_strobe && address inside {6'h0e, 6'h13} |=> read_data[5:3] == 3'h0)
        else $error("reserved config bits not zero");
    a_dc_active: assert property (chan_one_dc_block_active == (global_dc_block_coefficient != 4'h0 && !chan_one_dc_block_bypass))
        else $error("dc block active wrong");
endmodule // channel_cal_config_regs_props
`default_nettype wire

// ==== verification/channel_cal_config_regs_tb_top.sv ====
// self-checking bench for the channel config and calibration bank
`default_nettype none
module channel_cal_config_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock = 0, rst_n = 0, write_strobe = 0, read_strobe = 0, rd_d = 0;
    logic [5:0]  address = 0;
    logic [15:0] write_data = 0, read_data, model [0:63], q [$];
    logic [9:0]  ph1, ph2;
    logic        by1, by2, act1, act2;
    logic [1:0]  sel1, sel2;
    logic [23:0] off1, gain1;
    logic [3:0]  dcc;
    logic [7:0]  g0;
    int          mismatches = 0, n_tests = 0;
    bit   [31:0] seed = 33089;
    channel_cal_config_regs channel_cal_config_regs_inst (
        .clock(clock), .rst_n(rst_n), .address(address), .write_data(write_data),
        .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
        .chan_one_phase_delay(ph1), .chan_one_dc_block_bypass(by1), .chan_one_input_select(sel1),
        .chan_one_dc_block_active(act1), .chan_one_offset(off1), .chan_one_gain(gain1),
        .chan_two_phase_delay(ph2), .chan_two_dc_block_bypass(by2), .chan_two_input_select(sel2),
        .chan_two_dc_block_active(act2), .global_dc_block_coefficient(dcc), .chan_zero_gain_low_bits(g0));
    initial forever #4 clock = ~clock;
    // writable bits of each word
    function automatic logic [15:0] wmask(input logic [5:0] a);
        case (a)
            6'h0d, 6'h10, 6'h12: return 16'hff00;
            6'h0e, 6'h13: return 16'hffc7;
            6'h0f, 6'h11: return 16'hffff;
            6'h14: return 16'h000f;
            default: return 16'h0000;
        endcase
    endfunction
    function automatic logic [15:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction
    task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        address <= a;
        write_data <= d;
        write_strobe <= 1;
        read_strobe <= 0;
        model[a] = d & wmask(a);
        @(posedge clock);
    endtask
    task automatic rd(input logic [5:0] a);
        address <= a;
        read_strobe <= 1;
        write_strobe <= 0;
        q.push_back(model[a]);
        @(posedge clock);
    endtask
    task automatic idle();
        read_strobe <= 0;
        write_strobe <= 0;
        @(posedge clock);
    endtask
    task automatic reset_and_read_all();
        rst_n <= 0;
        read_strobe <= 0;
        write_strobe <= 0;
        repeat (6) @(posedge clock);
        rst_n <= 1;
        foreach (model[i]) model[i] = 16'h0000;
        model[17] = 16'h8000;
        for (int a = 0; a < 64; a++) rd(a[5:0]);
        $display("test reset values done");
    endtask
    // scoreboard: read data stands in the cycle after the strobe
    always @(posedge clock) begin
        if (rd_d && q.size() == 0) chk("unexpected read", 0, 1);
        else if (rd_d) chk("read_data", q.pop_front(), read_data);
        else if (rst_n && read_data !== 16'h0000) chk("idle read_data", 16'h0000, read_data);
        rd_d <= read_strobe;
    end
    initial begin
        #400000;
        mismatches++;
        stop_test();
    end
    initial begin
        logic [9:0] ph;
        reset_and_read_all();
        repeat (4) for (int a = 12; a < 22; a++) begin
            wr(a[5:0], rnd());
            rd(a[5:0]);
        end
        chk("gain", {model[17], model[18][15:8]}, gain1);
        chk("offset", {model[15], model[16][15:8]}, off1);
        chk("chan zero gain low", model[13][15:8], g0);
        chk("chan two", {model[19][15:6], model[19][2:0]}, {ph2, by2, sel2});
        $display("test random access done");
        for (int s = 0; s < 4; s++) begin
            ph = s[0] ? 10'h200 : 10'h1ff;
            wr(6'h0e, {ph, 3'b111, s[1], s[1:0]});
            rd(6'h0e);
            chk("chan one config", {ph, s[1], s[1:0]}, {ph1, by1, sel1});
        end
        $display("test select codes done");
        for (int c = 0; c < 4; c++) begin
            wr(6'h14, c[1] ? 16'hfff5 : 16'h0000);
            wr(6'h0e, {13'h0000, c[0], 2'h0});
            rd(6'h14);
            chk("dc block active", c == 2, act1);
            chk("chan two dc block active", c[1] && !model[19][2], act2);
            chk("coefficient", c[1] ? 4'h5 : 4'h0, dcc);
        end
        $display("test dc block done");
        reset_and_read_all();
        idle();
        for (int i = 0; i < 10 && q.size() > 0; i++) idle();
        if (q.size() > 0) chk("pending reads", 0, q.size());
        stop_test();
    end
endmodule // channel_cal_config_regs_tb_top
bind channel_cal_config_regs channel_cal_config_regs_props props_inst (.*);
`default_nettype wire
